/* File: isr_pkg.sv */
/*
 * constants, command codes and carriers for the status reporting block.
 * assumes a single 40 MHz clock and a command decoder in front.
 */
package isr_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_KHZ = 40000;
   localparam int GATE_TICK_US = 1000;
   localparam int GATE_TICK_CYC = CLK_KHZ * GATE_TICK_US / 1000;

   // ----------------------------------------------------------------
   // bit positions
   // ----------------------------------------------------------------
   localparam int QUES_DATA_LOSS = 0;
   localparam int QUES_CLOCK_LOSS = 9;
   localparam int QUES_SYNC_LOSS = 10;
   localparam int QUES_UNAVAIL = 11;
   localparam int QUES_RESYNC = 12;
   localparam int QUES_SUMMARY = 13;
   localparam int OPER_MEASURING = 4;
   localparam int OPER_BIT_ERR = 8;
   localparam int OPER_END_PER = 9;
   localparam int OPER_LOG_TEXT = 10;
   localparam int OPER_TCENTER = 11;
   localparam int OPER_ACENTER = 12;
   localparam int FAIL_BITS = 9;
   localparam int SREQ_CLOCK_SRC = 0;
   localparam int STB_SLAVE = 1;
   localparam int STB_QUES = 3;
   localparam int STB_ESB = 5;
   localparam int STB_RQS = 6;
   localparam int STB_OPER = 7;
   localparam int ESR_OPC = 0;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] enable;
      logic [15:0] rising_filter;
      logic [15:0] falling_filter;
   } isr_filter_s;

   typedef enum logic [4:0] {
      CMD_NONE, CMD_PRESET, CMD_CLS, CMD_OPC,
      CMD_RD_STB, CMD_RD_ESR, CMD_WR_ESE, CMD_WR_SRE,
      CMD_RD_QUES_EV, CMD_RD_QUES_CND, CMD_WR_QUES_EN,
      CMD_WR_QUES_RISE, CMD_WR_QUES_FALL,
      CMD_RD_OPER_EV, CMD_RD_OPER_CND, CMD_WR_OPER_EN,
      CMD_WR_OPER_RISE, CMD_WR_OPER_FALL,
      CMD_RD_FAIL_EV, CMD_RD_SREQ_EV, CMD_WR_SREQ_EN,
      CMD_RD_SREQ_EN, CMD_GATE_START, CMD_TCENTER, CMD_ACENTER
   } isr_cmd_e;

   typedef struct packed {
      isr_cmd_e code;
      logic [15:0] data;
   } isr_cmd_s;

   // ----------------------------------------------------------------
   // preset and reset values
   // ----------------------------------------------------------------
   localparam isr_filter_s SCPI_PRESET = '{16'h0000, 16'hffff, 16'h0000};
   localparam logic [15:0] DEV_PRESET_EN = 16'hffff;
   localparam isr_filter_s FAIL_FIXED = '{16'h01ff, 16'h01ff, 16'h0000};
   localparam logic [7:0] ESE_RESET = 8'h00;
   localparam logic [7:0] SRE_RESET = 8'h00;

endpackage

/* File: isr_status_group.sv */
/*
 * one condition/filter/event/enable group with a summary bit.
 * assumes filter settings held by the caller.
 */
`timescale 1ns/1ps
module isr_status_group (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [15:0] cond,
   input wire logic [15:0] direct,
   input wire isr_pkg::isr_filter_s filt,
   input wire logic clear,
   output logic [15:0] event_q,
   output logic summary_q
);

   logic [15:0] cond_q;
   logic [15:0] set_w;

   // ----------------------------------------------------------------
   // transition filters
   // ----------------------------------------------------------------
   // edge latch
   assign set_w = (cond & ~cond_q & filt.rising_filter) |
                  (~cond & cond_q & filt.falling_filter) | direct;

   // previous condition
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cond_q <= 16'h0000;
      end else begin
         cond_q <= cond;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         event_q <= 16'h0000;
      end else begin
         event_q <= (clear ? 16'h0000 : event_q) | set_w;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         summary_q <= 1'b0;
      end else begin
         summary_q <= |(event_q & filt.enable);
      end
   end

   AST_EVT_SET: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (set_w != 16'h0000) |=> ((event_q & $past(set_w)) == $past(set_w)))
      else $error("filtered edge not latched");

   AST_EVT_HOLD: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (!clear && set_w == 16'h0000) |=> $stable(event_q))
      else $error("event changed without cause");

   AST_SUMMARY: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      ##1 (summary_q == |($past(event_q) & $past(filt.enable))))
      else $error("summary disagrees with enabled events");

endmodule

/* File: isr_overlap_ctl.sv */
/*
 * overlapped operations: timed gating and eye centering.
 * assumes done strobes from the measurement logic are one-cycle pulses.
 */
`timescale 1ns/1ps
module isr_overlap_ctl #(
   parameter int TICK_CYC = isr_pkg::GATE_TICK_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic start_gate,
   input wire logic start_tc,
   input wire logic start_ac,
   input wire logic [15:0] gate_len,
   input wire logic tc_done,
   input wire logic ac_done,
   output logic gating_q,
   output logic tc_run_q,
   output logic ac_run_q,
   output logic end_period_q,
   output logic done_q
);

   typedef enum logic [1:0] {ST_IDLE, ST_GATE, ST_TC, ST_AC} isr_ovl_e;

   isr_ovl_e state_q;
   logic [31:0] div_q;
   logic tick_w;
   logic [15:0] left_q;
   logic expire_w;

   // ----------------------------------------------------------------
   // millisecond tick
   // ----------------------------------------------------------------
   assign tick_w = (div_q == 32'(TICK_CYC - 1));
   assign expire_w = (state_q == ST_GATE) && tick_w && (left_q == 16'h0001);

   always_ff @(posedge sys_clk) begin
      if (!rst_n || state_q != ST_GATE) begin
         div_q <= 32'h0000_0000;
      end else begin
         div_q <= tick_w ? 32'h0000_0000 : div_q + 32'h0000_0001;
      end
   end

   // ----------------------------------------------------------------
   // sequencer; a new start is ignored while one is running
   // ----------------------------------------------------------------
   // overlapped execution
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         left_q <= 16'h0000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start_gate) begin
                  state_q <= ST_GATE;
                  left_q <= (gate_len == 16'h0000) ? 16'h0001 : gate_len;
               end else if (start_tc) begin
                  state_q <= ST_TC;
               end else if (start_ac) begin
                  state_q <= ST_AC;
               end
            end
            ST_GATE: begin
               if (expire_w) begin
                  state_q <= ST_IDLE;
               end
               if (tick_w) begin
                  left_q <= left_q - 16'h0001;
               end
            end
            ST_TC: begin
               if (tc_done) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_AC: begin
               if (ac_done) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         done_q <= 1'b0;
         end_period_q <= 1'b0;
      end else begin
         end_period_q <= expire_w;
         done_q <= expire_w || (state_q == ST_TC && tc_done) ||
                   (state_q == ST_AC && ac_done);
      end
   end

   // running flags
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         gating_q <= 1'b0;
         tc_run_q <= 1'b0;
         ac_run_q <= 1'b0;
      end else begin
         gating_q <= (state_q == ST_GATE) && !expire_w;
         tc_run_q <= (state_q == ST_TC) && !tc_done;
         ac_run_q <= (state_q == ST_AC) && !ac_done;
      end
   end

   AST_DONE_CAUSE: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      done_q |-> $past(state_q) != ST_IDLE && state_q == ST_IDLE)
      else $error("completion without finished operation");

   AST_GATE_LEN: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (state_q == ST_IDLE && start_gate) |=> ##1 gating_q [*2])
      else $error("gating ended too early");

endmodule

/* File: isr_status_top.sv */
/*
 * status reporting structure: questionable, operation, hardware failure
 * and slave service groups, standard event register and status byte.
 * assumes commands arrive already parsed, one per valid cycle.
 */
// Notes on behaviour
// - questionable bit 11 follows the signal-unavailable condition
// - questionable bit 12 follows the first-pass resynchronisation
// - preset touches only enables and transition filters
// - preset leaves status byte and standard event register alone
// - preset clears no event register; only clear-status and event reads do
// - clear-status empties every event register
// - slave group on preset: enables all ones, no edge filters
// - standard groups on preset: rising edges only, enables zero
// - failure group has fixed enables and filters, no condition read
// - failure bits 0 to 8 name hardware faults, 9 to 15 undefined
// - slave group: readable writable enable, no filters, no condition
// - slave requests are captured directly as events
// - slave bit 0 is the clock source request, others undefined
// - gating and eye centering run overlapped, all else sequential
// - operation complete only after gating or centering has finished
// - status byte bit 1 shows a slave service request
// - operation bits 8 and 9 are events, the others conditions
`timescale 1ns/1ps
module isr_status_top #(
   parameter int TICK_CYC = isr_pkg::GATE_TICK_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire isr_pkg::isr_cmd_s cmd,
   input wire logic data_loss,
   input wire logic clock_loss,
   input wire logic sync_loss,
   input wire logic signal_unavailable,
   input wire logic resync_first_pass,
   input wire logic bit_error,
   input wire logic logged_text,
   input wire logic [8:0] hw_fail,
   input wire logic slave_req,
   input wire logic tc_done,
   input wire logic ac_done,
   output logic rsp_valid_q,
   output logic [15:0] rsp_data_q,
   output logic [7:0] stb_q,
   output logic srq_q,
   output logic gate_active_q,
   output logic tcenter_run_q,
   output logic acenter_run_q
);

   isr_pkg::isr_filter_s ques_filt_q, oper_filt_q, sreq_filt_w;
   logic [7:0] ese_q, sre_q, esr_q, stb_w;
   logic [15:0] sreq_en_q, ques_cond_w, oper_cond_w, oper_direct_w;
   logic [15:0] ques_ev, oper_ev, fail_ev, sreq_ev;
   logic ques_sum, oper_sum, fail_sum, sreq_sum;
   logic opc_pend_q, end_period, busy_w, cls_w, preset_w;

   // ----------------------------------------------------------------
   // command decode helpers
   // ----------------------------------------------------------------
   function automatic logic is_cmd(input logic v,
                                   input isr_pkg::isr_cmd_e c,
                                   input isr_pkg::isr_cmd_e want);
      return v && (c == want);
   endfunction

   assign cls_w = is_cmd(cmd_valid, cmd.code, isr_pkg::CMD_CLS);
   assign preset_w = is_cmd(cmd_valid, cmd.code, isr_pkg::CMD_PRESET);
   assign busy_w = gate_active_q || tcenter_run_q || acenter_run_q;

   // ----------------------------------------------------------------
   // condition vectors
   // ----------------------------------------------------------------
   // unavailable bit, resync bit
   always_comb begin
      ques_cond_w = 16'h0000;
      ques_cond_w[isr_pkg::QUES_DATA_LOSS] = data_loss;
      ques_cond_w[isr_pkg::QUES_CLOCK_LOSS] = clock_loss;
      ques_cond_w[isr_pkg::QUES_SYNC_LOSS] = sync_loss;
      ques_cond_w[isr_pkg::QUES_UNAVAIL] = signal_unavailable;
      ques_cond_w[isr_pkg::QUES_RESYNC] = resync_first_pass;
      ques_cond_w[isr_pkg::QUES_SUMMARY] = fail_sum;
   end

   // bits 8 and 9 bypass filters
   always_comb begin
      oper_cond_w = 16'h0000;
      oper_direct_w = 16'h0000;
      oper_cond_w[isr_pkg::OPER_MEASURING] = gate_active_q;
      oper_cond_w[isr_pkg::OPER_LOG_TEXT] = logged_text;
      oper_cond_w[isr_pkg::OPER_TCENTER] = tcenter_run_q;
      oper_cond_w[isr_pkg::OPER_ACENTER] = acenter_run_q;
      oper_direct_w[isr_pkg::OPER_BIT_ERR] = bit_error;
      oper_direct_w[isr_pkg::OPER_END_PER] = end_period;
   end

   assign sreq_filt_w = '{sreq_en_q, 16'h0000, 16'h0000};

   // ----------------------------------------------------------------
   // groups; event reads and clear-status empty them
   // ----------------------------------------------------------------
   // clear-status or read only
   isr_status_group u_ques (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .cond(ques_cond_w),
      .direct(16'h0000),
      .filt(ques_filt_q),
      .clear(cls_w || is_cmd(cmd_valid, cmd.code,
                             isr_pkg::CMD_RD_QUES_EV)),
      .event_q(ques_ev),
      .summary_q(ques_sum)
   );

   isr_status_group u_oper (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .cond(oper_cond_w),
      .direct(oper_direct_w),
      .filt(oper_filt_q),
      .clear(cls_w || is_cmd(cmd_valid, cmd.code,
                             isr_pkg::CMD_RD_OPER_EV)),
      .event_q(oper_ev),
      .summary_q(oper_sum)
   );

   // fixed failure masks, nine defined bits
   isr_status_group u_fail (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .cond({7'h00, hw_fail}),
      .direct(16'h0000),
      .filt(isr_pkg::FAIL_FIXED),
      .clear(cls_w || is_cmd(cmd_valid, cmd.code,
                             isr_pkg::CMD_RD_FAIL_EV)),
      .event_q(fail_ev),
      .summary_q(fail_sum)
   );

   isr_status_group u_sreq (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .cond(16'h0000),
      .direct({15'h0000, slave_req}),
      .filt(sreq_filt_w),
      .clear(cls_w || is_cmd(cmd_valid, cmd.code,
                             isr_pkg::CMD_RD_SREQ_EV)),
      .event_q(sreq_ev),
      .summary_q(sreq_sum)
   );

   // ----------------------------------------------------------------
   // overlapped operations
   // ----------------------------------------------------------------
   // overlapped starts
   isr_overlap_ctl #(
      .TICK_CYC(TICK_CYC)
   ) u_ovl (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start_gate(is_cmd(cmd_valid, cmd.code, isr_pkg::CMD_GATE_START)),
      .start_tc(is_cmd(cmd_valid, cmd.code, isr_pkg::CMD_TCENTER)),
      .start_ac(is_cmd(cmd_valid, cmd.code, isr_pkg::CMD_ACENTER)),
      .gate_len(cmd.data),
      .tc_done(tc_done),
      .ac_done(ac_done),
      .gating_q(gate_active_q),
      .tc_run_q(tcenter_run_q),
      .ac_run_q(acenter_run_q),
      .end_period_q(end_period),
      .done_q()
   );

   // ----------------------------------------------------------------
   // filter and enable registers
   // ----------------------------------------------------------------
   // preset here for standard groups, slave enable in the next block
   always_ff @(posedge sys_clk) begin
      if (!rst_n || preset_w) begin
         ques_filt_q <= isr_pkg::SCPI_PRESET;
         oper_filt_q <= isr_pkg::SCPI_PRESET;
      end else if (cmd_valid) begin
         case (cmd.code)
            isr_pkg::CMD_WR_QUES_EN: ques_filt_q.enable <= cmd.data;
            isr_pkg::CMD_WR_QUES_RISE: ques_filt_q.rising_filter <= cmd.data;
            isr_pkg::CMD_WR_QUES_FALL: ques_filt_q.falling_filter <= cmd.data;
            isr_pkg::CMD_WR_OPER_EN: oper_filt_q.enable <= cmd.data;
            isr_pkg::CMD_WR_OPER_RISE: oper_filt_q.rising_filter <= cmd.data;
            isr_pkg::CMD_WR_OPER_FALL: oper_filt_q.falling_filter <= cmd.data;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || preset_w) begin
         sreq_en_q <= isr_pkg::DEV_PRESET_EN;
      end else if (is_cmd(cmd_valid, cmd.code, isr_pkg::CMD_WR_SREQ_EN)) begin
         sreq_en_q <= cmd.data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ese_q <= isr_pkg::ESE_RESET;
         sre_q <= isr_pkg::SRE_RESET;
      end else begin
         if (is_cmd(cmd_valid, cmd.code, isr_pkg::CMD_WR_ESE)) begin
            ese_q <= cmd.data[7:0];
         end
         if (is_cmd(cmd_valid, cmd.code, isr_pkg::CMD_WR_SRE)) begin
            sre_q <= cmd.data[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // standard event register and operation complete
   // ----------------------------------------------------------------
   // complete waits on overlapped work, clear
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         opc_pend_q <= 1'b0;
         esr_q <= 8'h00;
      end else begin
         if (cls_w) begin
            opc_pend_q <= 1'b0;
         end else if (is_cmd(cmd_valid, cmd.code, isr_pkg::CMD_OPC)) begin
            opc_pend_q <= 1'b1;
         end else if (opc_pend_q && !busy_w) begin
            opc_pend_q <= 1'b0;
         end
         if (cls_w || is_cmd(cmd_valid, cmd.code, isr_pkg::CMD_RD_ESR)) begin
            esr_q <= 8'h00;
         end
         if (opc_pend_q && !busy_w) begin
            esr_q[isr_pkg::ESR_OPC] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // status byte and service request
   // ----------------------------------------------------------------
   // slave bit, summaries
   always_comb begin
      stb_w = 8'h00;
      stb_w[isr_pkg::STB_SLAVE] = sreq_sum;
      stb_w[isr_pkg::STB_QUES] = ques_sum;
      stb_w[isr_pkg::STB_ESB] = |(esr_q & ese_q);
      stb_w[isr_pkg::STB_OPER] = oper_sum;
      stb_w[isr_pkg::STB_RQS] = |(stb_w & sre_q);
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stb_q <= 8'h00;
         srq_q <= 1'b0;
      end else begin
         stb_q <= stb_w;
         srq_q <= stb_w[isr_pkg::STB_RQS];
      end
   end

   // ----------------------------------------------------------------
   // query answers, one cycle after the command
   // ----------------------------------------------------------------
   // no failure condition read, enable readable
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rsp_valid_q <= 1'b0;
         rsp_data_q <= 16'h0000;
      end else begin
         rsp_valid_q <= cmd_valid;
         case (cmd.code)
            isr_pkg::CMD_RD_STB: rsp_data_q <= {8'h00, stb_q};
            isr_pkg::CMD_RD_ESR: rsp_data_q <= {8'h00, esr_q};
            isr_pkg::CMD_RD_QUES_EV: rsp_data_q <= ques_ev;
            isr_pkg::CMD_RD_QUES_CND: rsp_data_q <= ques_cond_w;
            isr_pkg::CMD_RD_OPER_EV: rsp_data_q <= oper_ev;
            isr_pkg::CMD_RD_OPER_CND: rsp_data_q <= oper_cond_w;
            isr_pkg::CMD_RD_FAIL_EV: rsp_data_q <= fail_ev;
            isr_pkg::CMD_RD_SREQ_EV: rsp_data_q <= sreq_ev;
            isr_pkg::CMD_RD_SREQ_EN: rsp_data_q <= sreq_en_q;
            default: rsp_data_q <= 16'h0000;
         endcase
      end
   end

   AST_PRESET_KEEPS_EVENTS: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (preset_w && !cls_w && ques_cond_w == $past(ques_cond_w))
      |=> (ques_ev & $past(ques_ev)) == $past(ques_ev))
      else $error("preset lost a questionable event");

   AST_PRESET_VALUES: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      preset_w |=> sreq_en_q == 16'hffff && oper_filt_q.enable == 16'h0000
         && oper_filt_q.rising_filter == 16'hffff
         && ques_filt_q.falling_filter == 16'h0000)
      else $error("preset values wrong");

   AST_PRESET_ESR: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (preset_w && !(opc_pend_q && !busy_w)) |=> $stable(esr_q))
      else $error("preset changed standard event register");

   AST_CLS_EMPTY: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (cls_w && !slave_req && !bit_error && !end_period
         && !(opc_pend_q && !busy_w))
      |=> sreq_ev == 16'h0000 && esr_q == 8'h00)
      else $error("clear status left events");

   AST_SLAVE_STB: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (slave_req && sreq_en_q[0] && !preset_w) |-> ##3 stb_q[1])
      else $error("slave request missing from status byte");

   AST_UNAVAIL: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      ($rose(signal_unavailable) && ques_filt_q.rising_filter[11])
      |=> ques_ev[11])
      else $error("unavailable edge not latched");

   AST_OPC_WAIT: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (opc_pend_q && busy_w && !cls_w) |=> opc_pend_q)
      else $error("operation complete while overlapped work runs");

endmodule

/* File: isr_ctl_model.sv */
/*
 * controller model: issues one parsed command, takes the answer.
 * assumes the answer comes one cycle after the command is taken.
 */
`timescale 1ns/1ps
module isr_ctl_model (
   input wire logic sys_clk,
   output logic cmd_valid,
   output isr_pkg::isr_cmd_s cmd,
   input wire logic rsp_valid_q,
   input wire logic [15:0] rsp_data_q
);
   // idle command port
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end

   // one command, released lines show the inverse
   task automatic send(input isr_pkg::isr_cmd_e c, input logic [15:0] d,
                       output logic [15:0] r);
      @(posedge sys_clk);
      cmd_valid <= 1'b1;
      cmd <= '{c, d};
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      cmd <= isr_pkg::isr_cmd_s'(~{c, d});
      #1;
      r = rsp_valid_q ? rsp_data_q : 16'hdead;
   endtask
endmodule

/* File: tb_top.sv */
/*
 * self-checking bench for the status reporting block.
 * assumes the controller model drives the command port.
 */
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic [6:0] drv;
      logic [8:0] hw;
      isr_pkg::isr_cmd_e rd;
      logic [15:0] ev;
   } isr_row_s;
   logic sys_clk, rst_n, cmd_valid, rsp_valid_q, srq_q;
   logic gate_active_q, tcenter_run_q, acenter_run_q;
   logic [6:0] drv_q;
   logic [8:0] hw_q;
   logic [15:0] rsp_data_q, rd;
   logic [7:0] stb_q;
   isr_pkg::isr_cmd_s cmd;
   int err_total, num_checks, cyc;
   isr_row_s rows [5];

   isr_status_top #(.TICK_CYC(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd(cmd), .data_loss(drv_q[0]),
      .clock_loss(1'b0), .sync_loss(1'b0), .signal_unavailable(drv_q[1]),
      .resync_first_pass(drv_q[2]), .bit_error(drv_q[4]),
      .logged_text(1'b0), .hw_fail(hw_q), .slave_req(drv_q[3]),
      .tc_done(drv_q[5]), .ac_done(drv_q[6]), .rsp_valid_q(rsp_valid_q),
      .rsp_data_q(rsp_data_q), .stb_q(stb_q), .srq_q(srq_q),
      .gate_active_q(gate_active_q), .tcenter_run_q(tcenter_run_q),
      .acenter_run_q(acenter_run_q));
   isr_ctl_model ctl (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd(cmd),
      .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q));

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] s);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask

   task automatic tally_and_finish;
      if (err_total == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // clock and hang guard
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      drv_q = '0;
      hw_q = '0;
      rows[0] = '{7'h02, 9'h000, isr_pkg::CMD_RD_QUES_EV, 16'h0800};
      rows[1] = '{7'h04, 9'h000, isr_pkg::CMD_RD_QUES_EV, 16'h1000};
      rows[2] = '{7'h08, 9'h000, isr_pkg::CMD_RD_SREQ_EV, 16'h0001};
      rows[3] = '{7'h10, 9'h000, isr_pkg::CMD_RD_OPER_EV, 16'h0100};
      rows[4] = '{7'h00, 9'h101, isr_pkg::CMD_RD_FAIL_EV, 16'h0101};
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         @(posedge sys_clk) drv_q <= rows[i].drv;
         hw_q <= rows[i].hw;
         @(posedge sys_clk) drv_q <= '0;
         hw_q <= '0;
         repeat (3) @(posedge sys_clk);
         ctl.send(rows[i].rd, 16'h0000, rd);
         chk("row event", rows[i].ev, rd);
      end
      // preset keeps events, reloads filters
      ctl.send(isr_pkg::CMD_CLS, 16'h0000, rd);
      @(posedge sys_clk) drv_q <= 7'h01;
      ctl.send(isr_pkg::CMD_WR_QUES_FALL, 16'hffff, rd);
      ctl.send(isr_pkg::CMD_PRESET, 16'h0000, rd);
      ctl.send(isr_pkg::CMD_RD_QUES_EV, 16'h0000, rd);
      chk("ques kept", 16'h0001, rd);
      @(posedge sys_clk) drv_q <= 7'h00;
      repeat (3) @(posedge sys_clk);
      ctl.send(isr_pkg::CMD_RD_QUES_EV, 16'h0000, rd);
      chk("ques fall", 16'h0000, rd);
      ctl.send(isr_pkg::CMD_WR_SREQ_EN, 16'h0000, rd);
      ctl.send(isr_pkg::CMD_PRESET, 16'h0000, rd);
      ctl.send(isr_pkg::CMD_RD_SREQ_EN, 16'h0000, rd);
      chk("slave en", 16'hffff, rd);
      // slave request reaches the status byte, clear empties it
      @(posedge sys_clk) drv_q <= 7'h08;
      @(posedge sys_clk) drv_q <= 7'h00;
      repeat (4) @(posedge sys_clk);
      ctl.send(isr_pkg::CMD_PRESET, 16'h0000, rd);
      chk("stb slave", 16'h0001, {15'h0000, stb_q[1]});
      ctl.send(isr_pkg::CMD_WR_SRE, 16'h0002, rd);
      @(posedge sys_clk);
      #1 chk("srq", 16'h0001, {15'h0000, srq_q});
      ctl.send(isr_pkg::CMD_CLS, 16'h0000, rd);
      ctl.send(isr_pkg::CMD_RD_SREQ_EV, 16'h0000, rd);
      chk("slave clr", 16'h0000, rd);
      // gating with operation complete
      ctl.send(isr_pkg::CMD_GATE_START, 16'h0004, rd);
      ctl.send(isr_pkg::CMD_OPC, 16'h0000, rd);
      chk("gating", 16'h0001, {15'h0000, gate_active_q});
      ctl.send(isr_pkg::CMD_RD_ESR, 16'h0000, rd);
      chk("opc early", 16'h0000, rd);
      for (int n = 0; n < 40 && gate_active_q === 1'b1; n++) begin
         @(posedge sys_clk);
      end
      repeat (3) @(posedge sys_clk);
      ctl.send(isr_pkg::CMD_RD_ESR, 16'h0000, rd);
      chk("opc done", 16'h0001, rd);
      ctl.send(isr_pkg::CMD_RD_OPER_EV, 16'h0000, rd);
      chk("oper ev", 16'h0210, rd);
      // both centering operations
      for (int k = 0; k < 2; k++) begin
         ctl.send(k ? isr_pkg::CMD_ACENTER : isr_pkg::CMD_TCENTER, 16'h0, rd);
         repeat (2) @(posedge sys_clk);
         #1 chk("run", 16'h1, {15'h0, k ? acenter_run_q : tcenter_run_q});
         @(posedge sys_clk) drv_q <= k ? 7'h40 : 7'h20;
         @(posedge sys_clk) drv_q <= 7'h00;
         repeat (3) @(posedge sys_clk);
         #1 chk("end", 16'h0, {15'h0, k ? acenter_run_q : tcenter_run_q});
      end
      // mid-run reset restores the slave enable
      ctl.send(isr_pkg::CMD_WR_SREQ_EN, 16'h0000, rd);
      @(posedge sys_clk) rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      ctl.send(isr_pkg::CMD_RD_SREQ_EN, 16'h0000, rd);
      chk("rst slave en", 16'hffff, rd);
      tally_and_finish();
   end
endmodule
